// ===== design/e3ohi_port.sv
// Purpose: transmit overhead insertion port, strobe-and-insert method
// Assumes: terminal equipment runs on the line-rate clock, here core_clk
// Notes:   inserted bits leave on ovh_bit_out with a one-cycle valid
//          ovh_bit_* outputs expose the outbound overhead stream
//          slot period is SLOT_GAP plus four core_clk cycles
//          reset state is our own: outputs low, next bit is position 0
//
// What this block does
// - strobe goes high one cycle before each overhead bit is processed
// - boundary rises with strobe when next bit starts a new frame
// - count zero, first alignment byte msb, accepts insertion
// - counts one to twenty-three refuse insertion
// - counts twenty-four to twenty-nine accept path identifier bits 7..2
// - bytes go in fixed order, msb first, eight counts each
// - counts thirty to fifty-five accept insertion
// - request on a refused bit is ignored, internal value kept
// - data sampled every cycle, used only while request high, ignored when low
`timescale 1ns/1ps
module e3ohi_port #(
  parameter logic [7:0]  SLOT_GAP  = e3ohi_pkg::SLOT_GAP_CYCLES,
  parameter logic [55:0] OVH_TABLE = e3ohi_pkg::OVH_TABLE_DEFAULT
) (
  input  wire logic                         core_clk,
  input  wire logic                         nrst,
  input  wire logic                         tx_overhead_insert_request,
  input  wire logic                         tx_overhead_bit_in,
  output wire logic                         tx_overhead_slot_strobe,
  output wire logic                         tx_overhead_frame_boundary,
  output wire logic                         ovh_bit_out,
  output wire logic                         ovh_bit_valid,
  output wire logic [e3ohi_pkg::POS_W-1:0]  ovh_bit_pos,
  output wire logic                         ovh_bit_inserted,
  output wire logic                         ovh_insert_ignored
);
  import e3ohi_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // port state, one register for everything

  typedef struct packed {
    e3ohi_phase_t     phase;
    logic [7:0]       cnt;
    logic [POS_W-1:0] idx;
    logic             strobe;
    logic             boundary;
    logic             bit_out;
    logic             bit_valid;
    logic [POS_W-1:0] bit_pos;
    logic             inserted;
    logic             ignored;
    logic [1:0]       req_sync;
    logic [1:0]       dat_sync;
  } e3ohi_state_t;

  localparam e3ohi_state_t STATE_RESET = '{
    phase:     ph_gap,
    cnt:       CNT_RESET,
    idx:       POS_RESET,
    strobe:    1'b0,
    boundary:  1'b0,
    bit_out:   1'b0,
    bit_valid: 1'b0,
    bit_pos:   POS_RESET,
    inserted:  1'b0,
    ignored:   1'b0,
    req_sync:  2'h0,
    dat_sync:  2'h0
  };

  e3ohi_state_t st;
  e3ohi_state_t next_st;
  e3ohi_rom_if  rom ();

  ////////////////////////////////////////////////////////////////////////////
  // acceptance map of the overhead positions

  function automatic logic e3ohi_insertable(input logic [POS_W-1:0] pos);
    logic ok;
    ok = 1'b0;
    if (pos == POS_FIRST) begin
      ok = 1'b1;
    end else if (pos >= POS_REFUSED_FIRST && pos <= POS_REFUSED_LAST) begin
      ok = 1'b0;
    end else if (pos >= POS_PATH_ID_FIRST && pos <= POS_PATH_ID_HI_END) begin
      ok = 1'b1;
    end else if (pos > POS_PATH_ID_HI_END && pos <= POS_LAST) begin
      ok = 1'b1;
    end
    return ok;
  endfunction : e3ohi_insertable

  // positions run from the frame start to POS_LAST and then wrap
  function automatic logic [POS_W-1:0] e3ohi_next_pos(input logic [POS_W-1:0] pos);
    logic [POS_W-1:0] nxt;
    nxt = pos + POS_W'(1);
    if (pos >= POS_LAST) begin
      nxt = POS_FIRST;
    end
    return nxt;
  endfunction : e3ohi_next_pos

  // picks the table bit of a position; bit 7 of a byte goes out first
  function automatic logic e3ohi_msb_first_bit(
    input logic [7:0]       byte_val,
    input logic [POS_W-1:0] pos
  );
    logic [BYTE_SEL_W-1:0] bit_idx;
    bit_idx = 3'h7 - pos[BYTE_SEL_W-1:0];
    return byte_val[bit_idx];
  endfunction : e3ohi_msb_first_bit

  ////////////////////////////////////////////////////////////////////////////
  // internal overhead source

  assign rom.byte_sel = st.idx[POS_W-1:BYTE_SEL_W];

  e3ohi_table #(
    .TABLE (OVH_TABLE)
  ) u_table (
    .core_clk (core_clk),
    .nrst     (nrst),
    .rom      (rom.table_side)
  );

  ////////////////////////////////////////////////////////////////////////////
  // slot sequencer and insertion

  always_comb begin
    logic internal_bit;
    logic accept;
    internal_bit = 1'b0;
    accept       = 1'b0;
    next_st      = st;

    // pins are asynchronous to core_clk, so two flops before any use
    next_st.req_sync[0] = tx_overhead_insert_request;
    next_st.req_sync[1] = st.req_sync[0];
    next_st.dat_sync[0] = tx_overhead_bit_in;
    next_st.dat_sync[1] = st.dat_sync[0];
    next_st.bit_valid = 1'b0;
    next_st.ignored   = 1'b0;
    next_st.strobe    = 1'b0;
    next_st.boundary  = 1'b0;

    // msb first within each byte
    internal_bit = e3ohi_msb_first_bit(rom.byte_val, st.idx);

    case (st.phase)
      ph_gap: begin
        // gap length plus four fixed cycles makes the slot period
        next_st.cnt = st.cnt + 8'h01;
        if (st.cnt >= SLOT_GAP - 8'h01) begin
          next_st.cnt      = CNT_RESET;
          next_st.phase    = ph_strobe;
          next_st.strobe   = 1'b1;
          next_st.boundary = (st.idx == POS_FIRST);
        end
      end

      ph_strobe: begin
        // strobe cycle; the next cycle is the processing cycle
        next_st.phase = ph_wait;
        next_st.cnt   = CNT_RESET;
      end

      ph_wait: begin
        // the far end holds request, and data while requesting, until the next strobe, which
        // is what lets the synchroniser delay stand in for a falling edge;
        // two wait cycles, so the second flop holds the processing-cycle value
        next_st.cnt = st.cnt + 8'h01;
        if (st.cnt >= SYNC_WAIT_LAST) begin
          next_st.phase = ph_capture;
          next_st.cnt   = CNT_RESET;
        end
      end

      ph_capture: begin
        // a refused or unrequested slot keeps the table bit
        accept            = st.req_sync[1] && e3ohi_insertable(st.idx);
        next_st.bit_out   = accept ? st.dat_sync[1] : internal_bit;
        next_st.inserted  = accept;
        next_st.ignored   = st.req_sync[1] && !accept;
        next_st.bit_valid = 1'b1;
        next_st.bit_pos   = st.idx;
        next_st.idx       = e3ohi_next_pos(st.idx);
        next_st.phase     = ph_gap;
        next_st.cnt       = CNT_RESET;
      end
      default: begin
        next_st = STATE_RESET;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st <= STATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from the state register

  assign tx_overhead_slot_strobe    = st.strobe;
  assign tx_overhead_frame_boundary = st.boundary;

  assign ovh_bit_out                = st.bit_out;
  assign ovh_bit_valid              = st.bit_valid;
  assign ovh_bit_pos                = st.bit_pos;
  assign ovh_bit_inserted           = st.inserted;
  assign ovh_insert_ignored         = st.ignored;

endmodule : e3ohi_port

// ===== design/e3ohi_pkg.sv
// Purpose: shared constants for the E3 overhead insertion port
// Assumes: G.832 overhead sequence of seven bytes, one bit per strobe
// Notes:   positions are counted from the boundary-marked strobe
package e3ohi_pkg;

  localparam int unsigned OVH_BITS_PER_FRAME = 56;
  localparam int unsigned BITS_PER_BYTE      = 8;
  localparam int unsigned OVH_BYTES          = 7;
  localparam int unsigned POS_W              = 6;
  localparam int unsigned BYTE_SEL_W         = 3;

  // insertable and refused windows of the overhead sequence
  localparam logic [5:0] POS_FIRST          = 6'h00;
  localparam logic [5:0] POS_REFUSED_FIRST  = 6'h01;
  localparam logic [5:0] POS_REFUSED_LAST   = 6'h17;
  localparam logic [5:0] POS_PATH_ID_FIRST  = 6'h18;
  localparam logic [5:0] POS_PATH_ID_HI_END = 6'h1d;
  localparam logic [5:0] POS_LAST           = 6'h37;
  localparam logic [5:0] POS_RESET          = 6'h00;

  // timing counts in core_clk cycles
  localparam int unsigned SYNC_STAGES    = 2;
  localparam logic [7:0]  SLOT_GAP_CYCLES = 8'h0c;
  localparam logic [7:0]  SYNC_WAIT_LAST  = 8'h01;
  localparam logic [7:0]  CNT_RESET       = 8'h00;

  // default internally generated overhead, byte 0 in the top bits
  localparam logic [55:0] OVH_TABLE_DEFAULT = 56'h00000000000000;

  typedef enum logic [3:0] {
    ph_gap     = 4'h1,
    ph_strobe  = 4'h2,
    ph_wait    = 4'h4,
    ph_capture = 4'h8
  } e3ohi_phase_t;

endpackage : e3ohi_pkg

// ===== design/e3ohi_rom_if.sv
// Purpose: carries the byte select and byte value of the overhead table
// Assumes: one reader, one table
// Notes:   table data comes out of a register, one cycle after select
`timescale 1ns/1ps
interface e3ohi_rom_if;
  logic [2:0] byte_sel;
  logic [7:0] byte_val;
  modport reader (output byte_sel, input  byte_val);
  modport table_side (input  byte_sel, output byte_val);
endinterface : e3ohi_rom_if

// ===== design/e3ohi_table.sv
// Purpose: default overhead byte table with registered read
// Assumes: select stable for many cycles before use
// Notes:   unused selects read as zero
`timescale 1ns/1ps
module e3ohi_table #(
  parameter logic [55:0] TABLE = e3ohi_pkg::OVH_TABLE_DEFAULT
) (
  input wire logic        core_clk,
  input wire logic        nrst,
  e3ohi_rom_if.table_side rom
);
  import e3ohi_pkg::*;

  logic [7:0] next_val;
  logic [7:0] val;

  always_comb begin
    next_val = 8'h00;
    if (rom.byte_sel < BYTE_SEL_W'(OVH_BYTES)) begin
      next_val = TABLE[(OVH_BYTES - 1 - rom.byte_sel) * BITS_PER_BYTE +: BITS_PER_BYTE];
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      val <= 8'h00;
    end else begin
      val <= next_val;
    end
  end

  assign rom.byte_val = val;

endmodule : e3ohi_table

// ===== sim/e3ohi_monitor.sv
// Purpose: checks slot timing and insertion at the port pins
// Assumes: answer stands four cycles after its strobe
// Notes:   last_pos follows the previous emitted position
`timescale 1ns/1ps
module e3ohi_monitor
  import e3ohi_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       nrst,
  input wire logic       tx_overhead_insert_request,
  input wire logic       tx_overhead_bit_in,
  input wire logic       tx_overhead_slot_strobe,
  input wire logic       tx_overhead_frame_boundary,
  input wire logic       ovh_bit_out,
  input wire logic       ovh_bit_valid,
  input wire logic [5:0] ovh_bit_pos,
  input wire logic       ovh_bit_inserted,
  input wire logic       ovh_insert_ignored
);
  logic [5:0] last_pos;
  logic       seen;
  logic       refused;
  assign refused = ovh_bit_pos >= POS_REFUSED_FIRST && ovh_bit_pos <= POS_REFUSED_LAST;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      last_pos <= POS_RESET;
      seen     <= 1'b0;
    end else if (ovh_bit_valid) begin
      last_pos <= ovh_bit_pos;
      seen     <= 1'b1;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  AST_ANSWER: assert property (tx_overhead_slot_strobe |-> ##4 ovh_bit_valid)
    else $error("no bit four cycles after strobe");
  AST_NO_EXTRA: assert property (ovh_bit_valid |-> $past(tx_overhead_slot_strobe, 4))
    else $error("bit without strobe");
  AST_SPACING: assert property (tx_overhead_slot_strobe |=> !tx_overhead_slot_strobe [*8])
    else $error("strobes too close");
  AST_BOUNDARY: assert property (tx_overhead_frame_boundary |-> tx_overhead_slot_strobe)
    else $error("boundary without strobe");
  AST_START: assert property (ovh_bit_valid && ovh_bit_pos == POS_FIRST |->
    $past(tx_overhead_frame_boundary, 4)) else $error("frame start unmarked");
  AST_ORDER: assert property (ovh_bit_valid && seen |-> ovh_bit_pos ==
    ((last_pos == POS_LAST) ? POS_FIRST : last_pos + 6'h01)) else $error("bad order");
  AST_REFUSE: assert property (ovh_bit_valid && refused |->
    !ovh_bit_inserted && ovh_insert_ignored == $past(tx_overhead_insert_request, 3))
    else $error("refused slot inserted");
  AST_ACCEPT: assert property (ovh_bit_valid && !refused |->
    !ovh_insert_ignored && ovh_bit_inserted == $past(tx_overhead_insert_request, 3))
    else $error("open slot mishandled");
  AST_VALUE: assert property (ovh_bit_valid && ovh_bit_inserted |->
    ovh_bit_out == $past(tx_overhead_bit_in, 3)) else $error("wrong inserted bit");
  cover property (ovh_bit_valid && ovh_bit_inserted);
  cover property (ovh_insert_ignored);
  cover property (ovh_bit_valid && ovh_bit_pos == POS_LAST);
endmodule : e3ohi_monitor
bind e3ohi_port e3ohi_monitor u_mon (.*);

// ===== sim/e3ohi_partner.sv
// Purpose: terminal equipment that inserts bits picked by a mask
// Assumes: strobes and boundary sampled on core_clk
// Notes:   idle data line toggles so a stale value never passes
`timescale 1ns/1ps
module e3ohi_partner
  import e3ohi_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic        tx_overhead_slot_strobe,
  input wire logic        tx_overhead_frame_boundary,
  input wire logic [55:0] ins_mask,
  input wire logic [55:0] ins_val,
  output logic            tx_overhead_insert_request,
  output logic            tx_overhead_bit_in
);
  logic [5:0] cnt;
  logic [5:0] p;
  assign p = tx_overhead_frame_boundary ? POS_FIRST : cnt + 6'h01;
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= POS_RESET;
      tx_overhead_insert_request <= 1'b0;
      tx_overhead_bit_in <= 1'b0;
    end else if (tx_overhead_slot_strobe) begin
      cnt <= p;
      tx_overhead_insert_request <= ins_mask[POS_LAST - p];
      tx_overhead_bit_in <= ins_mask[POS_LAST - p] ? ins_val[POS_LAST - p] : ~tx_overhead_bit_in;
    end else if (!tx_overhead_insert_request) begin
      tx_overhead_bit_in <= ~tx_overhead_bit_in;
    end
  end
endmodule : e3ohi_partner

// ===== sim/test_e3_overhead_insert_port.sv
// Purpose: frame-level checks of the overhead insertion port
// Assumes: default slot gap, period sixteen cycles
// Notes:   a distinct table shows refused slots keep their own bit
`timescale 1ns/1ps
module test_e3_overhead_insert_port;
  import e3ohi_pkg::*;
  localparam logic [55:0] TBL = 56'h0123456789abcd;
  localparam logic [55:0] PAT = 56'hc3a50f965a3ce1;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic req, din, strobe, bnd, bout, valid, ins_o, ign;
  logic [5:0] pos;
  logic [55:0] ins_mask = 56'h0;
  logic [55:0] ins_val = 56'h0;
  int miscompares = 0;
  int compares = 0;
  always #20 core_clk = ~core_clk;
  e3ohi_port #(.OVH_TABLE(TBL)) dut (.core_clk(core_clk), .nrst(nrst),
    .tx_overhead_insert_request(req), .tx_overhead_bit_in(din),
    .tx_overhead_slot_strobe(strobe), .tx_overhead_frame_boundary(bnd), .ovh_bit_out(bout),
    .ovh_bit_valid(valid), .ovh_bit_pos(pos), .ovh_bit_inserted(ins_o), .ovh_insert_ignored(ign));
  e3ohi_partner far (.core_clk(core_clk), .nrst(nrst), .tx_overhead_slot_strobe(strobe),
    .tx_overhead_frame_boundary(bnd), .ins_mask(ins_mask), .ins_val(ins_val),
    .tx_overhead_insert_request(req), .tx_overhead_bit_in(din));
  task automatic check(string name, logic [8:0] seen, logic [8:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic final_report();
    if (miscompares == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask : tick
  ////////////////////////////////////////////////////////////////////////
  task automatic run_frame(input logic [55:0] m, input logic [55:0] v);
    logic ok;
    logic [8:0] exp_slot;
    ins_mask = m;
    ins_val = v;
    for (int k = 0; k < 2000 && bnd !== 1'b1; k++) tick();
    for (int i = 0; i < 56; i++) begin
      for (int k = 0; k < 20 && valid !== 1'b1; k++) tick();
      ok = m[55 - i] && (i == 0 || i > 23);
      exp_slot = {6'(i), ok, ok ? v[55 - i] : TBL[55 - i], m[55 - i] && !ok};
      check("slot", {pos, ins_o, bout, ign}, exp_slot);
      tick();
    end
  endtask : run_frame
  task automatic t_reset();
    repeat (15) @(posedge core_clk);
    #1;
    check("reset", {strobe, bnd, valid, pos}, 9'h000);
    @(posedge core_clk);
    nrst <= 1'b1;
  endtask : t_reset
  task automatic t_insert_all();
    run_frame(56'hffffffffffffff, PAT);
  endtask : t_insert_all
  task automatic t_sparse();
    run_frame(56'haaaaaaaaaaaaaa, ~PAT);
  endtask : t_sparse
  task automatic t_no_request();
    run_frame(56'h0, PAT);
  endtask : t_no_request
  ////////////////////////////////////////////////////////////////////////
  initial begin
    t_reset();
    t_insert_all();
    t_sparse();
    t_no_request();
    final_report();
  end
  initial begin
    #240000;
    miscompares++;
    final_report();
  end
endmodule : test_e3_overhead_insert_port
